// ---- hdl/csd_regs.vh ----
// Constants for the external chip-select decoder: register indexes,
// field positions, reset values and timing counts.
// Assumes it is included by bare name from every design file that needs it.
`ifndef CSD_REGS_VH
`define CSD_REGS_VH

// Register indexes; the AXI byte address is four times the index
`define CSD_IDX_LOWER     32'hfffff060
`define CSD_IDX_UPPER     32'hfffff062
`define CSD_IDX_TIMING    32'hfffff064
`define CSD_IDX_STATUS    32'hfffff066

// Reset values
`define CSD_MAP_RESET     16'h2c11
`define CSD_TIMING_RESET  32'h00000000

// Field positions inside the lower-area map
`define CSD_F_SEL0        0
`define CSD_F_SEL1        4
`define CSD_F_SEL2        8
`define CSD_F_SEL3        12
// Field positions inside the upper-area map
`define CSD_F_SEL7        0
`define CSD_F_SEL6        4
`define CSD_F_SEL5        8
`define CSD_F_SEL4        12

// Timing register: 3-bit wait count per select space, mode bit per space
`define CSD_WAIT_W        3
`define CSD_F_MODE        24

// Address map figures
`define CSD_FETCH_LIMIT   28'h4000000
`define CSD_TOP_8MB       5'h1f
`define CSD_MID_SPLIT     28'h8000000

// Pin input synchroniser depth; reads add one strobe cycle more than this
`define CSD_SYNC_LAT      3

// Bus responses
`define CSD_RESP_OKAY     2'b00
`define CSD_RESP_SLVERR   2'b10

`endif

// ---- hdl/csd_sync.v ----
// Three-stage synchroniser for pin inputs of any width.
// Assumes the input is asynchronous to ref_clk; the output follows once
// the second and third stages agree.
module csd_sync #(
   parameter W = 16
) (
   input  wire         ref_clk,
   input  wire         resetn,
   input  wire         ce,
   input  wire [W-1:0] pin_in,
   output reg  [W-1:0] sync_out
);
   reg [W-1:0] s1_reg;
   reg [W-1:0] s2_reg;
   reg [W-1:0] s3_reg;

   // Stage chain; first stage only feeds the second
   always @(posedge ref_clk) begin
      if (!resetn) begin
         s1_reg   <= {W{1'b0}};
         s2_reg   <= {W{1'b0}};
         s3_reg   <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else if (ce) begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg)
            sync_out <= s3_reg; // Change accepted once stable
      end
   end
endmodule // csd_sync

// ---- hdl/csd_cs_decode.v ----
// Combinational chip-select decoder for the whole 256 MB; mapped 2 MB blocks in the lowest and highest 8 MB.
// Assumes addr is a 28-bit byte address and both maps are stable.
`include "csd_regs.vh"
module csd_cs_decode (
   input  wire [27:0] addr,
   input  wire [15:0] lower_map,
   input  wire [15:0] upper_map,
   output reg  [7:0]  cs_n
);
   wire [3:0] lo_sel0;
   wire [3:0] lo_sel2;
   wire [3:0] up_sel7;
   wire [3:0] up_sel5;
   wire [1:0] blk;
   wire [1:0] up_idx;

   // Per-block enables; upper bit m serves block 7-m
   genvar m;
   generate
      for (m = 0; m < 4; m = m + 1) begin : g_blk
         assign lo_sel0[m] = lower_map[`CSD_F_SEL0 + m]; // [R12]
         assign lo_sel2[m] = lower_map[`CSD_F_SEL2 + m]; // [R13]
         assign up_sel5[m] = upper_map[`CSD_F_SEL5 + m]; // [R14]
         assign up_sel7[m] = upper_map[`CSD_F_SEL7 + m]; // [R15]
      end
   endgenerate

   assign blk    = addr[22:21];              // 2 MB block inside an 8 MB area [R7]
   assign up_idx = ~addr[22:21];             // Block 4 uses bit 3, block 7 bit 0

   // Fixed priority, defaults when no enable is set; selects 1,3,4,6 bits unused
   always @* begin
      cs_n = 8'hff;
      if (addr[27:23] == 5'h00) begin
         if (lo_sel0[blk])
            cs_n[0] = 1'b0;                  // [R9] [R18]
         else if (lo_sel2[blk])
            cs_n[2] = 1'b0;                  // [R9]
         else
            cs_n[1] = 1'b0;                  // [R10] [R18]
      end else if (addr[27:23] == `CSD_TOP_8MB) begin
         if (up_sel7[up_idx])
            cs_n[7] = 1'b0;                  // [R9]
         else if (up_sel5[up_idx])
            cs_n[5] = 1'b0;                  // [R9]
         else
            cs_n[6] = 1'b0;                  // [R11]
      end else if (addr < `CSD_MID_SPLIT) begin
         cs_n[3] = 1'b0;                     // Middle area from 8 MB up to 128 MB [R4]
      end else begin
         cs_n[4] = 1'b0;
      end
   end
endmodule // csd_cs_decode

// ---- hdl/csd_bus_ctrl.v ----
// External bus chip-select decoder and pin control.
// Assumes an AXI4-Lite master for the registers, a CPU that holds its
// request until cpu_done, and external devices on the pins.
// Assumes cpu_target is classed upstream and both maps are written once
// after reset; a map change during an external access is not guarded.
// External reads wait for the pin word to cross the synchroniser.
//
// Contract
// R1: internal memory access: data floats, controls idle
// R2: peripheral access: address out, controls idle
// R3: peripheral access drives data on write only
// R4: 256 MB split into 2 MB and 64 MB
// R5: wait and cycle mode per memory block
// R6: instruction fetch only below 64 MB
// R7: lowest and highest 8 MB in 2 MB blocks
// R8: 16-bit read/write maps, bit 1 enables
// R9: priority 0>2>1 lower, 7>5>6 upper
// R10: no select 0/2 bit gives select 1
// R11: no select 5/7 bit gives select 6
// R12: lower bits 0-3: select 0, blocks 0-3
// R13: select-2 bits map to blocks 0-3
// R14: select-5 bits map to blocks 7-4
// R15: select-7 bits map to blocks 7-4
// R16: software sets both maps once after reset
// R17: unused select bits stored, no effect
// R18: map 0703H: select 0 blocks 0-1, select 1 block 3
//
// The AXI4-Lite interface to the registers was decided locally.
`include "csd_regs.vh"
module csd_bus_ctrl #(
   parameter AW = 12
) (
   input  wire          ref_clk,
   input  wire          resetn,
   input  wire          ce,
   // AXI4-Lite register slave
   input  wire [AW-1:0] s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output wire          s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output wire          s_axi_wready,
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   input  wire [AW-1:0] s_axi_araddr,
   input  wire          s_axi_arvalid,
   output wire          s_axi_arready,
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready,
   // CPU access port
   input  wire          cpu_valid,
   input  wire [27:0]   cpu_addr,
   input  wire          cpu_write,
   input  wire          cpu_fetch,
   input  wire [1:0]    cpu_target,
   input  wire [15:0]   cpu_wdata,
   output reg  [15:0]   cpu_rdata,
   output reg           cpu_done,
   output reg           cpu_fault,
   // External pins
   output reg  [25:0]   ext_addr,
   output reg  [15:0]   ext_data_out,
   output reg           ext_data_oe_n,
   input  wire [15:0]   ext_data_in,
   output reg  [7:0]    ext_cs_n,
   output reg           ext_rd_n,
   output reg           ext_wr_n,
   output reg           ext_cycle_mode
);
   // CPU target classes
   localparam [1:0] TGT_EXT  = 2'd0;
   localparam [1:0] TGT_IMEM = 2'd1;
   localparam [1:0] TGT_PERI = 2'd2;
   // Access states
   localparam [0:0] ST_IDLE = 1'b0;
   localparam [0:0] ST_EXT  = 1'b1;
   // Byte addresses of the registers
   localparam [33:0] BA_LOWER  = {`CSD_IDX_LOWER, 2'b00};
   localparam [33:0] BA_UPPER  = {`CSD_IDX_UPPER, 2'b00};
   localparam [33:0] BA_TIMING = {`CSD_IDX_TIMING, 2'b00};
   localparam [33:0] BA_STATUS = {`CSD_IDX_STATUS, 2'b00};
   // Read wait covers the three sync stages and the synchroniser's output flop
   localparam [31:0] SYNC_DLY = `CSD_SYNC_LAT + 1;
   localparam [`CSD_WAIT_W:0] SYNC_CNT = SYNC_DLY[`CSD_WAIT_W:0];

   reg  [15:0]   lower_area_chip_select_map_reg;
   reg  [15:0]   upper_area_chip_select_map_reg;
   reg  [31:0]   block_timing_reg;
   reg  [AW-1:0] aw_addr_reg;
   reg           aw_full_reg;
   reg  [31:0]   w_data_reg;
   reg  [3:0]    w_strb_reg;
   reg           w_full_reg;
   reg  [0:0]    state_reg;
   reg  [`CSD_WAIT_W:0] cnt_reg;
   reg           last_fault_reg;
   wire [7:0]    dec_cs_n;
   wire [15:0]   data_in_sync;
   reg  [2:0]    space;
   reg  [31:0]   rd_word;
   reg           rd_hit;
   wire          fetch_bad;
   wire          aw_take;
   wire          w_take;
   wire          ar_take;
   wire          wr_fire;
   wire          wr_lower;
   wire          wr_upper;
   wire          wr_timing;
   wire          wr_status;
   wire          rd_lower;
   wire          rd_upper;
   wire          rd_timing;
   wire          rd_status;
   wire          cpu_take;
   wire [31:0]   status_word;
   wire [`CSD_WAIT_W:0] ext_load;

   // Pin data through the synchroniser
   csd_sync #(
      .W (16)
   ) u_sync (
      .ref_clk  (ref_clk),
      .resetn   (resetn),
      .ce       (ce),
      .pin_in   (ext_data_in),
      .sync_out (data_in_sync)
   );

   // Chip-select decode of the current CPU address
   csd_cs_decode u_dec (
      .addr      (cpu_addr),
      .lower_map (lower_area_chip_select_map_reg),
      .upper_map (upper_area_chip_select_map_reg),
      .cs_n      (dec_cs_n)
   );

   // Write channels accepted independently, held until the write lands
   assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
   assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   // Handshakes and register hits of the held write and the offered read
   assign aw_take   = s_axi_awvalid && s_axi_awready;
   assign w_take    = s_axi_wvalid && s_axi_wready;
   assign ar_take   = s_axi_arvalid && s_axi_arready;
   assign wr_fire   = aw_full_reg && w_full_reg;
   assign wr_lower  = (aw_addr_reg == BA_LOWER[AW-1:0]);
   assign wr_upper  = (aw_addr_reg == BA_UPPER[AW-1:0]);
   assign wr_timing = (aw_addr_reg == BA_TIMING[AW-1:0]);
   assign wr_status = (aw_addr_reg == BA_STATUS[AW-1:0]);
   assign rd_lower  = (s_axi_araddr == BA_LOWER[AW-1:0]);
   assign rd_upper  = (s_axi_araddr == BA_UPPER[AW-1:0]);
   assign rd_timing = (s_axi_araddr == BA_TIMING[AW-1:0]);
   assign rd_status = (s_axi_araddr == BA_STATUS[AW-1:0]);

   // Status word: driven selects, last fault, busy
   assign status_word = {16'h0000, ext_cs_n, 6'h00, last_fault_reg, state_reg};

   // Read mux over the register map
   always @* begin
      rd_word = 32'h00000000;
      rd_hit  = 1'b1;
      if (rd_lower)
         rd_word = {16'h0000, lower_area_chip_select_map_reg}; // [R8]
      else if (rd_upper)
         rd_word = {16'h0000, upper_area_chip_select_map_reg}; // [R8]
      else if (rd_timing)
         rd_word = block_timing_reg;
      else if (rd_status)
         rd_word = status_word;
      else
         rd_hit = 1'b0;
   end

   // Register slave: write and read channels
   always @(posedge ref_clk) begin
      if (!resetn) begin
         lower_area_chip_select_map_reg <= `CSD_MAP_RESET;
         upper_area_chip_select_map_reg <= `CSD_MAP_RESET;
         block_timing_reg <= `CSD_TIMING_RESET;
         aw_addr_reg  <= {AW{1'b0}};
         aw_full_reg  <= 1'b0;
         w_data_reg   <= 32'h00000000;
         w_strb_reg   <= 4'h0;
         w_full_reg   <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `CSD_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= `CSD_RESP_OKAY;
         s_axi_rdata  <= 32'h00000000;
      end else if (ce) begin
         if (aw_take) begin
            aw_addr_reg <= s_axi_awaddr;
            aw_full_reg <= 1'b1;
         end
         if (w_take) begin
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            w_full_reg <= 1'b1;
         end
         if (wr_fire) begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `CSD_RESP_OKAY;
            // All 16 map bits stored, unused ones included [R8] [R17]
            if (wr_lower) begin
               if (w_strb_reg[0])
                  lower_area_chip_select_map_reg[7:0] <= w_data_reg[7:0];
               if (w_strb_reg[1])
                  lower_area_chip_select_map_reg[15:8] <= w_data_reg[15:8];
            end else if (wr_upper) begin
               if (w_strb_reg[0])
                  upper_area_chip_select_map_reg[7:0] <= w_data_reg[7:0];
               if (w_strb_reg[1])
                  upper_area_chip_select_map_reg[15:8] <= w_data_reg[15:8];
            end else if (wr_timing) begin
               if (w_strb_reg[0])
                  block_timing_reg[7:0] <= w_data_reg[7:0];
               if (w_strb_reg[1])
                  block_timing_reg[15:8] <= w_data_reg[15:8];
               if (w_strb_reg[2])
                  block_timing_reg[23:16] <= w_data_reg[23:16];
               if (w_strb_reg[3])
                  block_timing_reg[31:24] <= w_data_reg[31:24];
            end else if (!wr_status) begin
               s_axi_bresp <= `CSD_RESP_SLVERR; // Unmapped
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_hit ? `CSD_RESP_OKAY : `CSD_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Select space number of the decoded chip select
   always @* begin
      case (dec_cs_n)
         8'hfe:   space = 3'd0;
         8'hfd:   space = 3'd1;
         8'hfb:   space = 3'd2;
         8'hf7:   space = 3'd3;
         8'hef:   space = 3'd4;
         8'hdf:   space = 3'd5;
         8'hbf:   space = 3'd6;
         default: space = 3'd7;
      endcase
   end

   // Program area is the lowest 64 MB only
   assign fetch_bad = cpu_fetch && (cpu_addr >= `CSD_FETCH_LIMIT); // [R6]

   // A request still high in its done cycle is not taken twice
   assign cpu_take = cpu_valid && !cpu_done;

   // Wait count of an external access; reads add the synchroniser delay [R5]
   assign ext_load = {1'b0, block_timing_reg[space * `CSD_WAIT_W +: `CSD_WAIT_W]}
                     + (cpu_write ? {(`CSD_WAIT_W + 1){1'b0}} : SYNC_CNT);

   // CPU access sequencer and pin drivers
   always @(posedge ref_clk) begin
      if (!resetn) begin
         state_reg      <= ST_IDLE;
         cnt_reg        <= {(`CSD_WAIT_W + 1){1'b0}};
         last_fault_reg <= 1'b0;
         cpu_rdata      <= 16'h0000;
         cpu_done       <= 1'b0;
         cpu_fault      <= 1'b0;
         ext_addr       <= 26'h0000000;
         ext_data_out   <= 16'h0000;
         ext_data_oe_n  <= 1'b1;
         ext_cs_n       <= 8'hff;
         ext_rd_n       <= 1'b1;
         ext_wr_n       <= 1'b1;
         ext_cycle_mode <= 1'b0;
      end else if (ce) begin
         cpu_done  <= 1'b0;
         cpu_fault <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               // Idle pins: data floats, every control inactive
               ext_data_oe_n <= 1'b1;
               ext_cs_n      <= 8'hff;
               ext_rd_n      <= 1'b1;
               ext_wr_n      <= 1'b1;
               if (cpu_take) begin
                  last_fault_reg <= fetch_bad;
                  if (fetch_bad) begin
                     cpu_fault <= 1'b1;         // Refused fetch [R6]
                     cpu_done  <= 1'b1;
                  end else if (cpu_target == TGT_IMEM) begin
                     cpu_done <= 1'b1;          // Address left as is, data floats [R1]
                  end else if (cpu_target == TGT_PERI) begin
                     ext_addr      <= cpu_addr[25:0];  // [R2]
                     ext_data_out  <= cpu_wdata;
                     ext_data_oe_n <= !cpu_write;      // [R3]
                     cpu_done      <= 1'b1;
                  end else if (cpu_target == TGT_EXT) begin
                     ext_addr       <= cpu_addr[25:0];
                     ext_data_out   <= cpu_wdata;
                     ext_data_oe_n  <= !cpu_write;
                     ext_cs_n       <= dec_cs_n;       // [R7] [R9]
                     ext_rd_n       <= cpu_write;
                     ext_wr_n       <= !cpu_write;
                     // Per-space wait and cycle mode [R5]
                     ext_cycle_mode <= block_timing_reg[`CSD_F_MODE + space];
                     cnt_reg <= ext_load;
                     state_reg <= ST_EXT;
                  end else begin
                     cpu_done <= 1'b1;          // Unused class ends at once
                  end
               end
            end
            ST_EXT: begin
               // Strobes stand until the count runs out, then the settled word is taken
               if (cnt_reg == {(`CSD_WAIT_W + 1){1'b0}}) begin
                  cpu_rdata     <= data_in_sync;
                  cpu_done      <= 1'b1;
                  ext_data_oe_n <= 1'b1;
                  ext_cs_n      <= 8'hff;
                  ext_rd_n      <= 1'b1;
                  ext_wr_n      <= 1'b1;
                  state_reg     <= ST_IDLE;
               end else begin
                  cnt_reg <= cnt_reg - 1'b1;   // Wait states
               end
            end
            // Unused state code falls back to idle
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
endmodule // csd_bus_ctrl

// ---- sim/csd_bus_monitor.sv ----
// Concurrent checks on the chip-select decoder's top-level ports.
// Assumes one clock, ref_clk, and the synchronous active-low resetn.
module csd_bus_monitor (
   input wire        ref_clk,
   input wire        resetn,
   input wire        cpu_valid,
   input wire [27:0] cpu_addr,
   input wire        cpu_write,
   input wire        cpu_fetch,
   input wire [1:0]  cpu_target,
   input wire [15:0] cpu_wdata,
   input wire        cpu_done,
   input wire        cpu_fault,
   input wire [25:0] ext_addr,
   input wire [15:0] ext_data_out,
   input wire        ext_data_oe_n,
   input wire [7:0]  ext_cs_n,
   input wire        ext_rd_n,
   input wire        ext_wr_n,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_rvalid,
   input wire        s_axi_arready
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   wire strobe = !ext_rd_n || !ext_wr_n;
   a_fetch_fault: assert property (cpu_fault |-> cpu_done && cpu_addr >= 28'h4000000)
      else $error("fault on a legal address");
   a_fetch_quiet: assert property (cpu_valid && cpu_fetch && cpu_target == 2'h0
      && cpu_addr >= 28'h4000000 |-> &ext_cs_n && ext_rd_n) else $error("refused fetch on pins");
   a_internal_idle: assert property (cpu_valid && cpu_target == 2'h1
      |-> &ext_cs_n && ext_rd_n && ext_wr_n && ext_data_oe_n) else $error("pins busy internal");
   a_periph_addr: assert property (cpu_done && cpu_valid && cpu_target == 2'h2
      |-> ext_addr == cpu_addr[25:0] && &ext_cs_n && ext_rd_n && ext_wr_n)
      else $error("peripheral address or controls wrong");
   a_periph_drive: assert property ($fell(ext_data_oe_n) && cpu_target == 2'h2
      |-> cpu_write && ext_data_out == cpu_wdata) else $error("peripheral data drive wrong");
   a_lower_select: assert property (strobe && cpu_addr[27:23] == 5'h0
      |-> ext_cs_n[7:3] == 5'h1f && $countones(~ext_cs_n) == 1) else $error("lower select bad");
   a_upper_select: assert property (strobe && cpu_addr[27:23] == 5'h1f
      |-> ext_cs_n[4:0] == 5'h1f && $countones(~ext_cs_n) == 1) else $error("upper select bad");
   a_read_wait: assert property ($fell(ext_rd_n) |-> ##[5:12] cpu_done)
      else $error("read not done in time");
   a_resp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
endmodule // csd_bus_monitor

bind csd_bus_ctrl csd_bus_monitor u_csd_bus_monitor (.ref_clk, .resetn, .cpu_valid, .cpu_addr,
   .cpu_write, .cpu_fetch, .cpu_target, .cpu_wdata, .cpu_done, .cpu_fault, .ext_addr,
   .ext_data_out, .ext_data_oe_n, .ext_cs_n, .ext_rd_n, .ext_wr_n, .s_axi_bvalid,
   .s_axi_bready, .s_axi_rvalid, .s_axi_arready);

// ---- sim/csd_ext_mem.sv ----
// Behavioural external memory on the decoder's pins.
// Assumes active-low selects and strobes; idle data toggles every cycle.
module csd_ext_mem (
   input  wire         ref_clk,
   input  wire  [25:0] ext_addr,
   input  wire  [7:0]  ext_cs_n,
   input  wire         ext_rd_n,
   input  wire         ext_wr_n,
   input  wire  [15:0] ext_data_out,
   output logic [15:0] ext_data_in,
   output logic [15:0] last_wr
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] idle_q = 16'h0;
   wire         sel = ~&ext_cs_n;
   // Address pattern while read, a changing value once released
   assign ext_data_in = (sel && !ext_rd_n) ? ext_addr[15:0] ^ 16'h5a5a : idle_q;
   // Idle pattern flips; written words are captured
   always @(posedge ref_clk) begin
      idle_q <= ~ext_data_in;
      if (sel && !ext_wr_n) last_wr <= ext_data_out;
   end
   initial last_wr = 16'h0;
endmodule // csd_ext_mem

// ---- sim/csd_bus_ctrl_bench.sv ----
// Self-checking bench: AXI register access, CPU requests, external memory.
// Assumes the decoder's register and access timing as built.
module csd_bus_ctrl_bench;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {logic [15:0] lo; logic [15:0] up; logic [27:0] a; logic [7:0] cs;}
      csd_row_t;
   logic        ref_clk = 1'h0, resetn = 1'h0, cpu_valid = 1'h0, cpu_write = 1'h0;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, cpu_fetch = 1'h0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [1:0]  cpu_target = 2'h0;
   logic [27:0] cpu_addr = 28'h0;
   logic [15:0] cpu_wdata = 16'h0;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire  [15:0] cpu_rdata, ext_data_out, ext_data_in, last_wr;
   wire         cpu_done, cpu_fault, ext_data_oe_n, ext_rd_n, ext_wr_n, ext_cycle_mode;
   wire  [25:0] ext_addr;
   wire  [7:0]  ext_cs_n;
   int          fails = 0, compares = 0, lat;
   logic [7:0]  seen_cs;
   logic        seen_oe;
   csd_row_t    rows [13] = '{
      '{16'h0703, 16'h2c11, 28'h0000000, 8'hfe}, '{16'h0703, 16'h2c11, 28'h0200000, 8'hfe},
      '{16'h0703, 16'h2c11, 28'h0400000, 8'hfb}, '{16'h0703, 16'h2c11, 28'h0600000, 8'hfd},
      '{16'h0008, 16'h2c11, 28'h0600000, 8'hfe}, '{16'h0800, 16'h2c11, 28'h0600000, 8'hfb},
      '{16'hf0f0, 16'h2c11, 28'h0000000, 8'hfd}, '{16'h2c11, 16'h0001, 28'hfe00000, 8'h7f},
      '{16'h2c11, 16'h0100, 28'hfe00000, 8'hdf}, '{16'h2c11, 16'h0101, 28'hfe00000, 8'h7f},
      '{16'h2c11, 16'h0800, 28'hf800000, 8'hdf}, '{16'h2c11, 16'h0008, 28'hf800000, 8'h7f},
      '{16'h2c11, 16'hf0f0, 28'hfa00000, 8'hbf}};

   csd_bus_ctrl #(.AW(12)) u_csd_bus_ctrl (.ref_clk, .resetn, .ce(1'h1), .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .cpu_valid, .cpu_addr, .cpu_write, .cpu_fetch, .cpu_target, .cpu_wdata,
      .cpu_rdata, .cpu_done, .cpu_fault, .ext_addr, .ext_data_out, .ext_data_oe_n,
      .ext_data_in, .ext_cs_n, .ext_rd_n, .ext_wr_n, .ext_cycle_mode);
   csd_ext_mem u_csd_ext_mem (.ref_clk, .ext_addr, .ext_cs_n, .ext_rd_n, .ext_wr_n,
      .ext_data_out, .ext_data_in, .last_wr);

   // 40 MHz clock
   always #12.5 ref_clk = ~ref_clk;

   task automatic chk(input [31:0] got, input [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic do_reset();
      @(posedge ref_clk);
      resetn <= 1'h0;
      repeat (12) @(posedge ref_clk);
      resetn <= 1'h1;
   endtask

   // Write address and data offered together, each dropped when taken
   task automatic axi_wr(input [11:0] a, input [31:0] d, input [1:0] er);
      int n;
      n = 0;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge ref_clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1 && n < 50);
      chk(s_axi_bvalid, 1'h1);
      chk(s_axi_bresp, er);
      s_axi_bready <= 1'h0;
   endtask

   task automatic axi_rd(input [11:0] a, input [31:0] ed, input [1:0] er);
      int n;
      n = 0;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge ref_clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1 && n < 50);
      chk(s_axi_rvalid, 1'h1);
      chk(s_axi_rdata, ed);
      chk(s_axi_rresp, er);
      s_axi_rready <= 1'h0;
   endtask

   // CPU request held until done; pins are gathered over every cycle
   task automatic cpu_acc(input [1:0] t, input [27:0] a, input w, input f, input [15:0] d);
      @(posedge ref_clk);
      cpu_target <= t;
      cpu_addr <= a;
      cpu_write <= w;
      cpu_fetch <= f;
      cpu_wdata <= d;
      cpu_valid <= 1'h1;
      lat = 0;
      seen_cs = 8'hff;
      seen_oe = 1'h1;
      do begin
         @(posedge ref_clk);
         lat++;
         seen_cs &= ext_cs_n;
         seen_oe &= ext_data_oe_n;
      end while (cpu_done !== 1'h1 && lat < 40);
      chk(cpu_done, 1'h1);
      cpu_valid <= 1'h0;
   endtask

   task automatic print_verdict();
      $display("Compares %0d, fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   // Main sequence: table of decode cases, then hand-written cases
   initial begin
      foreach (rows[i]) begin
         do_reset();
         axi_wr(12'h180, {16'h0, rows[i].lo}, 2'h0);
         axi_wr(12'h188, {16'h0, rows[i].up}, 2'h0);
         axi_rd(12'h180, {16'h0, rows[i].lo}, 2'h0);
         axi_rd(12'h188, {16'h0, rows[i].up}, 2'h0);
         cpu_acc(2'h0, rows[i].a, 1'h0, 1'h0, 16'h0);
         chk(seen_cs, rows[i].cs);
         chk(cpu_rdata, rows[i].a[15:0] ^ 16'h5a5a);
         chk(lat, 7);
         $display("Decode row %0d done", i);
      end
      do_reset();
      axi_rd(12'h180, 32'h2c11, 2'h0);
      axi_rd(12'h188, 32'h2c11, 2'h0);
      axi_wr(12'h1a0, 32'hffff, 2'h2);
      axi_rd(12'h1a0, 32'h0, 2'h2);
      $display("Reset values and unmapped access done");
      cpu_acc(2'h0, 28'h4000000, 1'h0, 1'h1, 16'h0);
      chk({cpu_fault, seen_cs}, 9'h1ff);
      cpu_acc(2'h0, 28'h3fffffe, 1'h0, 1'h1, 16'h0);
      chk({cpu_fault, seen_cs}, 9'h0f7);
      cpu_acc(2'h1, 28'h0000000, 1'h1, 1'h0, 16'h1111);
      chk({seen_cs, seen_oe}, 9'h1ff);
      chk(lat, 2);
      cpu_acc(2'h2, 28'hffff040, 1'h1, 1'h0, 16'h1234);
      chk({seen_cs, seen_oe}, 9'h1fe);
      chk(ext_addr, 26'h3fff040);
      cpu_acc(2'h2, 28'hffff042, 1'h0, 1'h0, 16'h0);
      chk({seen_cs, seen_oe}, 9'h1ff);
      $display("Fetch limit, internal and peripheral cases done");
      axi_wr(12'h190, 32'h01000003, 2'h0);
      cpu_acc(2'h0, 28'h0000010, 1'h1, 1'h0, 16'hbeef);
      chk(lat, 6);
      chk(last_wr, 16'hbeef);
      chk(ext_cycle_mode, 1'h1);
      cpu_acc(2'h0, 28'h0000010, 1'h0, 1'h0, 16'h0);
      chk(lat, 10);
      chk(cpu_rdata, 16'h5a4a);
      $display("Wait state cases done");
      print_verdict();
   end

   // Watchdog well beyond the expected run
   initial begin
      #400000;
      fails++;
      print_verdict();
   end
endmodule // csd_bus_ctrl_bench
